// [rtl/dcbc_regs.vh]
// constants for the debug command and break control block
// assumes byte-wide command stream and 8-bit control/status registers
`ifndef DCBC_REGS_VH
`define DCBC_REGS_VH

// ****************************************
// command bytes
// ****************************************
`define DCBC_CMD_RD_STAT   8'h02
`define DCBC_CMD_WR_CTL    8'h04
`define DCBC_CMD_RD_CTL    8'h05
`define DCBC_CMD_WR_PM     8'h0a
`define DCBC_CMD_RD_PM     8'h0b
`define DCBC_CMD_WR_DM     8'h0c
`define DCBC_CMD_RD_DM     8'h0d
`define DCBC_CMD_CRC       8'h0e
`define DCBC_CMD_STEP      8'h10
`define DCBC_CMD_STUFF     8'h11
`define DCBC_CMD_EXEC      8'h12
`define DCBC_CMD_RD_BAUD   8'h1b

// ****************************************
// debug_control fields
// ****************************************
`define DCBC_CTL_HALT      7
`define DCBC_CTL_BRK_EN    6
`define DCBC_CTL_ACK_EN    5
`define DCBC_CTL_LOOP      4
`define DCBC_CTL_PC_BRK    3
`define DCBC_CTL_ZERO_BRK  2
`define DCBC_CTL_RSVD      1
`define DCBC_CTL_RST       0
`define DCBC_CTL_RESET     8'h00

// ****************************************
// other values
// ****************************************
`define DCBC_BAUD_RESET    12'h000
`define DCBC_FILL_BYTE     8'hff
`define DCBC_ACK_BYTE      8'hff
`define DCBC_CRC_PRESET    16'hffff
`define DCBC_CRC_POLY_REV  16'h8408
`define DCBC_SIZE_ZERO     17'h10000

`endif

// [rtl/dcbc_buf2.v]
// two-entry buffer between the command engine and the debug link sender
// assumes both sides on one clock; out side may stall at will
`timescale 1ns/1ps
module dcbc_buf2 #(
  parameter W = 8
)(
  // clock and reset
  input  wire         i_ref_clk,
  input  wire         i_rst,
  // fill side
  input  wire         i_in_valid,
  input  wire [W-1:0] i_in_data,
  output wire         o_in_ready,
  // drain side
  output wire         o_out_valid,
  output wire [W-1:0] o_out_data,
  input  wire         i_out_ready
);

  reg [W-1:0] mem_reg [0:1];
  reg         wp_reg;
  reg         rp_reg;
  reg [1:0]   cnt_reg;
  wire        push;
  wire        pop;

  assign o_in_ready  = (cnt_reg != 2'd2);
  assign o_out_valid = (cnt_reg != 2'd0);
  assign o_out_data  = mem_reg[rp_reg];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'd0;
    end
    else
    begin
      if (push)
      begin
        mem_reg[wp_reg] <= i_in_data;
        wp_reg          <= ~wp_reg;
      end
      if (pop)
        rp_reg <= ~rp_reg;
      if (push & ~pop)
        cnt_reg <= cnt_reg + 2'd1;
      else if (pop & ~push)
        cnt_reg <= cnt_reg - 2'd1;
    end
  end

endmodule

// [rtl/dcbc_core.v]
// debug command handler with breakpoint, counter and control logic
// assumes link framing delivers whole bytes on this clock, memories
// answer a read strobe with data on the following cycle, and the cpu
// decoder gives the instruction length of o_insn_byte combinationally
//
// Contract
// - program read: cmd, addr hi/lo, size hi/lo, then size bytes out; 0 = 65536
// - program read returns ffh outside debug mode or under read protect
// - data write: cmd, addr, size, data; dropped outside debug or read protect
// - data read: cmd, addr, size, then size bytes out; zero size = 65536
// - data read returns ffh outside debug mode; read protect does not block
// - crc command: ccitt crc, preset ones, lsb first, inverted, high first
// - crc outside debug mode returns ffffh
// - crc answer comes about one clock per program byte later
// - step runs one instruction; ignored outside debug or read protect
// - stuff sends opcode byte to cpu; ignored outside debug or read protect
// - execute passes 1-7 instruction bytes; ignored outside debug/protect
// - baud readback returns 12-bit reload value in two bytes, high byte first
// - control 81h resets and stops, 41h resets and runs, 40h resumes
// - control bit 7 halts fetches; set by hardware on enabled breakpoint
// - bit 6 clear makes breakpoint opcode a no-op; set enables action
// - bit 5 sends ffh on breakpoint, then clears itself
// - bit 4 clear halts on breakpoint; set makes the cpu loop on it
// - bit 3 compares counter with pc to halt; counter frozen while running
// - bit 2 halts when counter decrements to zero; no reload on resume
// - bit 0 resets device except debugger; clears when reset completes
// - status 7 halted or break since last control write; 6 halt; 4-0 zero
// - status 5 is one when the read-protect option bit is zero
// - program write stores only if unlocked, halted and not protected
`timescale 1ns/1ps
`include "dcbc_regs.vh"
module dcbc_core #(
  parameter [16:0] PM_BYTES = 17'h10000
)(
  // clock and reset
  input  wire        i_ref_clk,
  input  wire        i_rst,
  // command bytes from the link
  input  wire        i_rx_valid,
  input  wire [7:0]  i_rx_data,
  output wire        o_rx_ready,
  // answer bytes to the link
  output wire        o_tx_valid,
  output wire [7:0]  o_tx_data,
  input  wire        i_tx_ready,
  // program and data memory
  output reg  [15:0] o_mem_addr,
  output reg  [7:0]  o_mem_wdata,
  output reg         o_pm_rd,
  output reg         o_pm_wr,
  output reg         o_dm_rd,
  output reg         o_dm_wr,
  input  wire [7:0]  i_pm_rdata,
  input  wire [7:0]  i_dm_rdata,
  // cpu side
  input  wire [15:0] i_cpu_pc,
  input  wire        i_brk_decoded,
  input  wire        i_cpu_halt,
  input  wire [2:0]  i_op_len,
  output wire        o_cpu_stop,
  output wire        o_brk_as_nop,
  output wire        o_brk_loop,
  output reg         o_step,
  output reg         o_stuff,
  output reg         o_exec_valid,
  output reg         o_exec_last,
  output reg  [7:0]  o_insn_byte,
  // device reset request
  output wire        o_dev_rst,
  input  wire        i_dev_rst_done,
  // option bit, flash unlock, counter load, autobaud
  input  wire        i_rp_option,
  input  wire        i_flash_unlocked,
  input  wire        i_cnt_wr,
  input  wire [15:0] i_cnt_wdata,
  input  wire        i_baud_load,
  input  wire [11:0] i_baud_value,
  // register view
  output wire [7:0]  o_debug_control,
  output wire [7:0]  o_debug_status
);

  // ****************************************
  // states
  // ****************************************
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_AH   = 4'h1;
  localparam [3:0] S_AL   = 4'h2;
  localparam [3:0] S_SH   = 4'h3;
  localparam [3:0] S_SL   = 4'h4;
  localparam [3:0] S_RD   = 4'h5;
  localparam [3:0] S_RW1  = 4'h6;
  localparam [3:0] S_RW2  = 4'h7;
  localparam [3:0] S_PUSH = 4'h8;
  localparam [3:0] S_WD   = 4'h9;
  localparam [3:0] S_CRC  = 4'ha;
  localparam [3:0] S_CTL  = 4'hb;
  localparam [3:0] S_STF  = 4'hc;
  localparam [3:0] S_EXF  = 4'hd;
  localparam [3:0] S_EXL  = 4'he;
  localparam [3:0] S_EXN  = 4'hf;

  reg [3:0]  state_reg;
  reg [7:0]  cmd_reg;
  reg [15:0] addr_reg;
  reg [7:0]  szh_reg;
  reg [16:0] size_reg;
  reg [7:0]  tx_byte_reg;
  reg [7:0]  lo_byte_reg;
  reg        lo_pend_reg;
  reg        ack_push_reg;
  reg        ack_pend_reg;
  reg [7:0]  ctl_reg;
  reg        brk_seen_reg;
  reg [15:0] cnt_reg;
  reg [11:0] baud_reg;
  reg [15:0] crc_reg;
  reg [16:0] crc_left_reg;
  reg [1:0]  crc_pend_reg;
  reg [2:0]  exn_left_reg;

  wire       dbg;
  wire       rpa;
  wire       rx_fire;
  wire       push_valid;
  wire       push_ready;
  wire       brk_hit;
  wire       pc_hit;
  wire       cnt_dec;
  wire       zero_hit;
  wire       set_dbg;
  wire       is_pm;
  wire       rd_block;
  wire       wr_ok;
  wire       run_ok;
  wire [15:0] sz16;

  // ****************************************
  // crc byte step
  // ****************************************
  function [15:0] crc_step;
    input [15:0] c;
    input [7:0]  d;
    integer      k;
    reg [15:0]   x;
    begin
      x = c;
      for (k = 0; k < 8; k = k + 1)
        x = (x[0] ^ d[k]) ? ((x >> 1) ^ `DCBC_CRC_POLY_REV) : (x >> 1);
      crc_step = x;
    end
  endfunction

  // ****************************************
  // qualifiers
  // ****************************************
  assign dbg      = ctl_reg[`DCBC_CTL_HALT];
  assign rpa      = ~i_rp_option;
  assign is_pm    = (cmd_reg == `DCBC_CMD_RD_PM) | (cmd_reg == `DCBC_CMD_WR_PM);
  assign rd_block = is_pm ? (~dbg | rpa) : ~dbg;
  assign wr_ok    = is_pm ? (i_flash_unlocked & dbg & ~rpa)
                          : (dbg & ~rpa);
  assign run_ok   = dbg & ~rpa;
  assign sz16     = {szh_reg, i_rx_data};
  assign rx_fire  = i_rx_valid & o_rx_ready;

  assign o_rx_ready = ((state_reg == S_IDLE) & ~ack_pend_reg) |
                      (state_reg == S_AH) | (state_reg == S_AL) |
                      (state_reg == S_SH) | (state_reg == S_SL) |
                      (state_reg == S_WD) | (state_reg == S_CTL) |
                      (state_reg == S_STF) | (state_reg == S_EXF) |
                      (state_reg == S_EXN);

  // ****************************************
  // break sources
  // ****************************************
  assign brk_hit  = i_brk_decoded & ctl_reg[`DCBC_CTL_BRK_EN];
  assign pc_hit   = ctl_reg[`DCBC_CTL_PC_BRK] & ~dbg & (i_cpu_pc == cnt_reg);
  assign cnt_dec  = ~dbg & ~ctl_reg[`DCBC_CTL_PC_BRK] & (cnt_reg != 16'h0000);
  assign zero_hit = ctl_reg[`DCBC_CTL_ZERO_BRK] & cnt_dec & (cnt_reg == 16'h0001);
  assign set_dbg  = (brk_hit & ~ctl_reg[`DCBC_CTL_LOOP]) | pc_hit | zero_hit;

  assign o_cpu_stop      = dbg;
  assign o_brk_as_nop    = ~ctl_reg[`DCBC_CTL_BRK_EN];
  assign o_brk_loop      = ctl_reg[`DCBC_CTL_BRK_EN] & ctl_reg[`DCBC_CTL_LOOP];
  assign o_dev_rst       = ctl_reg[`DCBC_CTL_RST];
  assign o_debug_control = ctl_reg;
  assign o_debug_status  = {dbg | brk_seen_reg, i_cpu_halt, rpa, 5'h00};

  // ****************************************
  // answer path
  // ****************************************
  assign push_valid = (state_reg == S_PUSH);

  dcbc_buf2 #(
    .W (8)
  ) u_buf (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_in_valid  (push_valid),
    .i_in_data   (tx_byte_reg),
    .o_in_ready  (push_ready),
    .o_out_valid (o_tx_valid),
    .o_out_data  (o_tx_data),
    .i_out_ready (i_tx_ready)
  );

  // ****************************************
  // engine
  // ****************************************
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      state_reg    <= S_IDLE;
      cmd_reg      <= 8'h00;
      addr_reg     <= 16'h0000;
      szh_reg      <= 8'h00;
      size_reg     <= 17'h00000;
      tx_byte_reg  <= 8'h00;
      lo_byte_reg  <= 8'h00;
      lo_pend_reg  <= 1'b0;
      ack_push_reg <= 1'b0;
      ack_pend_reg <= 1'b0;
      ctl_reg      <= `DCBC_CTL_RESET;
      brk_seen_reg <= 1'b0;
      cnt_reg      <= 16'h0000;
      baud_reg     <= `DCBC_BAUD_RESET;
      crc_reg      <= `DCBC_CRC_PRESET;
      crc_left_reg <= 17'h00000;
      crc_pend_reg <= 2'b00;
      exn_left_reg <= 3'h0;
      o_mem_addr   <= 16'h0000;
      o_mem_wdata  <= 8'h00;
      o_pm_rd      <= 1'b0;
      o_pm_wr      <= 1'b0;
      o_dm_rd      <= 1'b0;
      o_dm_wr      <= 1'b0;
      o_step       <= 1'b0;
      o_stuff      <= 1'b0;
      o_exec_valid <= 1'b0;
      o_exec_last  <= 1'b0;
      o_insn_byte  <= 8'h00;
    end
    else
    begin
      o_pm_rd      <= 1'b0;
      o_pm_wr      <= 1'b0;
      o_dm_rd      <= 1'b0;
      o_dm_wr      <= 1'b0;
      o_step       <= 1'b0;
      o_stuff      <= 1'b0;
      o_exec_valid <= 1'b0;
      o_exec_last  <= 1'b0;
      if (i_baud_load)
        baud_reg <= i_baud_value;
      if (i_cnt_wr)
        cnt_reg <= i_cnt_wdata;
      else if (cnt_dec)
        cnt_reg <= cnt_reg - 16'h0001;
      if (i_dev_rst_done)
        ctl_reg[`DCBC_CTL_RST] <= 1'b0;
      case (state_reg)
        S_IDLE:
        begin
          lo_pend_reg <= 1'b0;
          if (ack_pend_reg)
          begin
            tx_byte_reg  <= `DCBC_ACK_BYTE;
            ack_push_reg <= 1'b1;
            state_reg    <= S_PUSH;
          end
          else if (rx_fire)
          begin
            cmd_reg <= i_rx_data;
            case (i_rx_data)
              `DCBC_CMD_RD_STAT:
              begin
                tx_byte_reg <= o_debug_status;
                state_reg   <= S_PUSH;
              end
              `DCBC_CMD_WR_CTL: state_reg <= S_CTL;
              `DCBC_CMD_RD_CTL:
              begin
                tx_byte_reg <= ctl_reg;
                state_reg   <= S_PUSH;
              end
              `DCBC_CMD_WR_PM, `DCBC_CMD_RD_PM,
              `DCBC_CMD_WR_DM, `DCBC_CMD_RD_DM: state_reg <= S_AH;
              `DCBC_CMD_CRC:
              begin
                if (~dbg)
                begin
                  tx_byte_reg <= `DCBC_FILL_BYTE;
                  lo_byte_reg <= `DCBC_FILL_BYTE;
                  lo_pend_reg <= 1'b1;
                  state_reg   <= S_PUSH;
                end
                else
                begin
                  crc_reg      <= `DCBC_CRC_PRESET;
                  crc_left_reg <= PM_BYTES;
                  crc_pend_reg <= 2'b00;
                  addr_reg     <= 16'h0000;
                  state_reg    <= S_CRC;
                end
              end
              `DCBC_CMD_STEP: o_step <= run_ok;
              `DCBC_CMD_STUFF: state_reg <= S_STF;
              `DCBC_CMD_EXEC: state_reg <= S_EXF;
              `DCBC_CMD_RD_BAUD:
              begin
                tx_byte_reg <= {4'h0, baud_reg[11:8]};
                lo_byte_reg <= baud_reg[7:0];
                lo_pend_reg <= 1'b1;
                state_reg   <= S_PUSH;
              end
              default: state_reg <= S_IDLE;
            endcase
          end
        end
        S_AH: if (rx_fire) begin addr_reg[15:8] <= i_rx_data; state_reg <= S_AL; end
        S_AL: if (rx_fire) begin addr_reg[7:0] <= i_rx_data; state_reg <= S_SH; end
        S_SH: if (rx_fire) begin szh_reg <= i_rx_data; state_reg <= S_SL; end
        S_SL:
        begin
          if (rx_fire)
          begin
            size_reg  <= (sz16 == 16'h0000) ? `DCBC_SIZE_ZERO : {1'b0, sz16};
            state_reg <= ((cmd_reg == `DCBC_CMD_WR_PM) | (cmd_reg == `DCBC_CMD_WR_DM))
                         ? S_WD : S_RD;
          end
        end
        S_RD:
        begin
          if (rd_block)
          begin
            tx_byte_reg <= `DCBC_FILL_BYTE;
            state_reg   <= S_PUSH;
          end
          else
          begin
            o_mem_addr <= addr_reg;
            o_pm_rd    <= is_pm;
            o_dm_rd    <= ~is_pm;
            state_reg  <= S_RW1;
          end
          addr_reg <= addr_reg + 16'h0001;
          size_reg <= size_reg - 17'h00001;
        end
        S_RW1: state_reg <= S_RW2;
        S_RW2:
        begin
          tx_byte_reg <= is_pm ? i_pm_rdata : i_dm_rdata;
          state_reg   <= S_PUSH;
        end
        S_PUSH:
        begin
          if (push_ready)
          begin
            if (ack_push_reg)
            begin
              ack_push_reg <= 1'b0;
              ack_pend_reg <= 1'b0;
              ctl_reg[`DCBC_CTL_ACK_EN] <= 1'b0;
            end
            if (lo_pend_reg & ~ack_push_reg)
            begin
              tx_byte_reg <= lo_byte_reg;
              lo_pend_reg <= 1'b0;
            end
            else if (~ack_push_reg & (size_reg != 17'h00000) &
                     ((cmd_reg == `DCBC_CMD_RD_PM) | (cmd_reg == `DCBC_CMD_RD_DM)))
              state_reg <= S_RD;
            else
              state_reg <= S_IDLE;
          end
        end
        S_WD:
        begin
          if (rx_fire)
          begin
            o_mem_addr  <= addr_reg;
            o_mem_wdata <= i_rx_data;
            o_pm_wr     <= is_pm & wr_ok;
            o_dm_wr     <= ~is_pm & wr_ok;
            addr_reg    <= addr_reg + 16'h0001;
            size_reg    <= size_reg - 17'h00001;
            if (size_reg == 17'h00001)
              state_reg <= S_IDLE;
          end
        end
        S_CRC:
        begin
          if (crc_pend_reg[1])
            crc_reg <= crc_step(crc_reg, i_pm_rdata);
          crc_pend_reg <= {crc_pend_reg[0], crc_left_reg != 17'h00000};
          if (crc_left_reg != 17'h00000)
          begin
            o_mem_addr   <= addr_reg;
            o_pm_rd      <= 1'b1;
            addr_reg     <= addr_reg + 16'h0001;
            crc_left_reg <= crc_left_reg - 17'h00001;
          end
          else if (crc_pend_reg == 2'b00)
          begin
            tx_byte_reg <= ~crc_reg[15:8];
            lo_byte_reg <= ~crc_reg[7:0];
            lo_pend_reg <= 1'b1;
            state_reg   <= S_PUSH;
          end
        end
        S_CTL:
        begin
          if (rx_fire)
          begin
            ctl_reg   <= {i_rx_data[7:2], 1'b0, i_rx_data[0]};
            state_reg <= S_IDLE;
          end
        end
        S_STF:
        begin
          if (rx_fire)
          begin
            o_insn_byte <= i_rx_data;
            o_stuff     <= run_ok;
            state_reg   <= S_IDLE;
          end
        end
        S_EXF:
        begin
          if (rx_fire)
          begin
            o_insn_byte <= i_rx_data;
            state_reg   <= S_EXL;
          end
        end
        S_EXL:
        begin
          o_exec_valid <= run_ok;
          o_exec_last  <= (i_op_len <= 3'd1);
          exn_left_reg <= (i_op_len == 3'd0) ? 3'd0 : i_op_len - 3'd1;
          state_reg    <= (i_op_len <= 3'd1) ? S_IDLE : S_EXN;
        end
        S_EXN:
        begin
          if (rx_fire)
          begin
            o_insn_byte  <= i_rx_data;
            o_exec_valid <= run_ok;
            o_exec_last  <= (exn_left_reg == 3'd1);
            exn_left_reg <= exn_left_reg - 3'd1;
            if (exn_left_reg == 3'd1)
              state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
      // control write clears the break memory; a new break wins
      if ((state_reg == S_CTL) & rx_fire)
        brk_seen_reg <= 1'b0;
      if (brk_hit)
        brk_seen_reg <= 1'b1;
      if (set_dbg)
        ctl_reg[`DCBC_CTL_HALT] <= 1'b1;
      if ((set_dbg | brk_hit) & ctl_reg[`DCBC_CTL_ACK_EN])
        ack_pend_reg <= 1'b1;
    end
  end

endmodule

// [rtl/dcbc_dummy_unused.v]
// spare source slot; the block is built from dcbc_core and dcbc_buf2 only
// assumes nothing; it holds no module, so no stray top level can appear

// [tb/dcbc_mem_model.sv]
// program and data memory model for the debug command bench
// assumes read data is wanted one cycle after a read strobe
`timescale 1ns/1ps
module dcbc_mem_model (
  input  wire        i_ref_clk,
  input  wire [15:0] i_addr,
  input  wire [7:0]  i_wdata,
  input  wire        i_pm_rd,
  input  wire        i_dm_rd,
  input  wire        i_dm_wr,
  output reg  [7:0]  o_pm_rdata,
  output reg  [7:0]  o_dm_rdata
);
  reg [7:0] dm [0:255];
  initial o_pm_rdata = 8'h00;
  initial o_dm_rdata = 8'h00;
  // data toggles when not read, so a stale byte never passes
  always @(posedge i_ref_clk)
  begin
    o_pm_rdata <= i_pm_rd ? (i_addr[7:0] ^ 8'h5a) : ~o_pm_rdata;
    o_dm_rdata <= i_dm_rd ? dm[i_addr[7:0]] : ~o_dm_rdata;
    if (i_dm_wr)
      dm[i_addr[7:0]] <= i_wdata;
  end
endmodule

// [tb/dcbc_core_asserts.sv]
// port checker for the debug command block
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module dcbc_core_asserts (
  input wire       i_ref_clk,
  input wire       i_rst,
  input wire       i_rp_option,
  input wire       i_cpu_halt,
  input wire       i_brk_decoded,
  input wire       i_flash_unlocked,
  input wire       o_cpu_stop,
  input wire       o_brk_as_nop,
  input wire       o_brk_loop,
  input wire       o_step,
  input wire       o_pm_wr,
  input wire       o_dm_wr,
  input wire       o_dev_rst,
  input wire [7:0] o_debug_control,
  input wire [7:0] o_debug_status
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  ctl_reset_a: assert property (disable iff (1'b0) i_rst |=> o_debug_control == 8'h00)
    else $error("control not cleared by reset");
  stat_bits_a: assert property (o_debug_status[4:0] == 5'h00 && o_debug_status[6] == i_cpu_halt)
    else $error("status low bits wrong");
  stat_rp_a: assert property (o_debug_status[5] == !i_rp_option)
    else $error("status protect bit wrong");
  ctl_outs_a: assert property (o_cpu_stop == o_debug_control[7] && o_dev_rst == o_debug_control[0])
    else $error("control outputs differ");
  brk_mode_a: assert property (o_brk_as_nop == !o_debug_control[6] && !o_debug_control[1])
    else $error("breakpoint nop wrong");
  loop_out_a: assert property (o_brk_loop == (o_debug_control[6] && o_debug_control[4]))
    else $error("loop output wrong");
  brk_halt_a: assert property (i_brk_decoded && o_debug_control[6] && !o_debug_control[4]
    |=> o_debug_control[7] && o_debug_status[7]) else $error("no halt on break");
  brk_loop_a: assert property (i_brk_decoded && o_debug_control[6] && o_debug_control[4]
    |=> o_debug_status[7]) else $error("loop break not seen");
  step_gate_a: assert property (o_step |-> $past(o_debug_control[7]) && $past(i_rp_option))
    else $error("step while not allowed");
  pm_gate_a: assert property (o_pm_wr |-> $past(i_flash_unlocked) && $past(i_rp_option)
    && $past(o_debug_control[7])) else $error("program write not allowed");
  dm_gate_a: assert property (o_dm_wr |-> $past(o_debug_control[7]) && $past(i_rp_option))
    else $error("data write not allowed");
  step_c: cover property (o_step);
  halt_c: cover property ($rose(o_debug_control[7]));
  pmwr_c: cover property (o_pm_wr);
endmodule
bind dcbc_core dcbc_core_asserts u_chk (.*);

// [tb/dcbc_core_tb.sv]
// self-checking bench for the debug command block
// assumes the memory model and checker files are compiled first
`timescale 1ns/1ps
`include "dcbc_regs.vh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin mismatches++; \
  $display("MISMATCH %0t got %h exp %h", $time, (a), (e)); end end
module dcbc_core_tb;
  logic i_ref_clk = 0, i_rst = 1, i_rx_valid = 0, i_tx_ready = 0, i_brk_decoded = 0;
  logic i_cpu_halt = 0, i_dev_rst_done = 0, i_rp_option = 1, i_flash_unlocked = 1;
  logic i_cnt_wr = 0, i_baud_load = 0;
  logic [7:0] i_rx_data = 0, d;
  logic [15:0] i_cpu_pc = 0, i_cnt_wdata = 0, a, c;
  logic [2:0] i_op_len = 3'h1;
  logic [11:0] i_baud_value = 0;
  wire o_rx_ready, o_tx_valid, o_pm_rd, o_pm_wr, o_dm_rd, o_dm_wr, o_cpu_stop, o_dev_rst;
  wire o_brk_as_nop, o_brk_loop, o_step, o_stuff, o_exec_valid, o_exec_last;
  wire [7:0] o_tx_data, o_mem_wdata, i_pm_rdata, i_dm_rdata, o_insn_byte;
  wire [7:0] o_debug_control, o_debug_status;
  wire [15:0] o_mem_addr;
  logic [7:0] exp_q[$];
  int mismatches = 0, check_count = 0;
  dcbc_core #(.PM_BYTES(17'h00010)) uut (.*);
  dcbc_mem_model u_mem (.i_ref_clk(i_ref_clk), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata),
    .i_pm_rd(o_pm_rd), .i_dm_rd(o_dm_rd), .i_dm_wr(o_dm_wr),
    .o_pm_rdata(i_pm_rdata), .o_dm_rdata(i_dm_rdata));
  initial forever #2.5 i_ref_clk = ~i_ref_clk;
  // the link stalls at random so the answer buffer fills
  always @(posedge i_ref_clk) i_tx_ready <= #1 $urandom_range(1, 0);
  // pulse counters for the cpu and program write strobes
  logic [7:0] n_step = 0, n_stuff = 0, n_exec = 0, n_last = 0, n_pmwr = 0;
  always @(posedge i_ref_clk)
  begin
    n_step  <= n_step + o_step;
    n_stuff <= n_stuff + o_stuff;
    n_exec  <= n_exec + o_exec_valid;
    n_last  <= n_last + o_exec_last;
    n_pmwr  <= n_pmwr + o_pm_wr;
  end
  always @(posedge i_ref_clk)
    if (o_tx_valid && i_tx_ready)
    begin
      `CHK(o_tx_data, exp_q.size() ? exp_q[0] : 8'hxx)
      if (exp_q.size())
        void'(exp_q.pop_front());
    end
  function automatic logic [7:0] pmv(input logic [15:0] x);
    return x[7:0] ^ 8'h5a;
  endfunction
  function automatic logic [15:0] crc_of(input int n);
    logic [15:0] r;
    logic [7:0] b;
    r = 16'hffff;
    for (int i = 0; i < n; i++)
    begin
      b = pmv(i[15:0]);
      for (int k = 0; k < 8; k++)
        r = (r >> 1) ^ ((r[0] ^ b[k]) ? 16'h8408 : 16'h0000);
    end
    return ~r;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic send(input logic [7:0] b);
    i_rx_valid = 1;
    i_rx_data = b;
    #3;
    while (!o_rx_ready)
    begin
      @(posedge i_ref_clk);
      #4;
    end
    tick(1);
  endtask
  task automatic cmd(input logic [7:0] q[$]); // only listed command bytes are sent
    tick(1);
    foreach (q[i]) send(q[i]);
    i_rx_valid = 0;
  endtask
  task automatic ex(input logic [7:0] q[$]);
    foreach (q[i]) exp_q.push_back(q[i]);
  endtask
  task automatic rdm(input logic [7:0] k, input logic [15:0] x, input logic [15:0] n);
    cmd('{k, x[15:8], x[7:0], n[15:8], n[7:0]});
  endtask
  task automatic breakpoint_opcode;
    i_brk_decoded = 1;
    tick(1);
    i_brk_decoded = 0;
  endtask
  task automatic drain(input string s);
    repeat (3000) if (exp_q.size()) @(posedge i_ref_clk);
    tick(1);
    `CHK(exp_q.size(), 0)
    $display("test done: %s", s);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    mismatches++;
    close_out;
  end
  initial
  begin
    void'($urandom(32'h166e7603));
    tick(10);
    i_rst = 0;
    ex('{8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff});
    cmd('{`DCBC_CMD_RD_STAT});
    rdm(`DCBC_CMD_RD_PM, 16'h0010, 16'h0002);
    rdm(`DCBC_CMD_RD_DM, 16'h0010, 16'h0003);
    cmd('{`DCBC_CMD_CRC});
    drain("running reads");
    i_baud_value = 12'habc;
    i_baud_load = 1;
    tick(1);
    i_baud_load = 0;
    ex('{8'h0a, 8'hbc, 8'h80, 8'h80});
    cmd('{`DCBC_CMD_RD_BAUD});
    cmd('{`DCBC_CMD_WR_CTL, 8'h80});
    cmd('{`DCBC_CMD_RD_CTL});
    cmd('{`DCBC_CMD_RD_STAT});
    drain("baud and halt");
    a = 16'($urandom);
    d = 8'($urandom);
    ex('{pmv(a), pmv(a + 1), pmv(a + 2), d, ~d});
    rdm(`DCBC_CMD_RD_PM, a, 16'h0003);
    cmd('{`DCBC_CMD_WR_DM, a[15:8], a[7:0], 8'h00, 8'h02, d, ~d});
    rdm(`DCBC_CMD_RD_DM, a, 16'h0002);
    cmd('{`DCBC_CMD_WR_PM, 8'h00, 8'h00, 8'h00, 8'h01, d});
    i_flash_unlocked = 0;
    cmd('{`DCBC_CMD_WR_PM, 8'h00, 8'h01, 8'h00, 8'h01, d});
    drain("halted memory");
    i_rp_option = 0;
    i_cpu_halt = 1;
    ex('{8'hff, d, 8'he0});
    cmd('{`DCBC_CMD_WR_DM, a[15:8], a[7:0], 8'h00, 8'h01, ~d});
    rdm(`DCBC_CMD_RD_PM, a, 16'h0001);
    rdm(`DCBC_CMD_RD_DM, a, 16'h0001);
    cmd('{`DCBC_CMD_RD_STAT});
    cmd('{`DCBC_CMD_STEP});
    drain("read protect");
    i_rp_option = 1;
    i_cpu_halt = 0;
    c = crc_of(16);
    ex('{c[15:8], c[7:0]});
    cmd('{`DCBC_CMD_CRC});
    cmd('{`DCBC_CMD_STEP});
    cmd('{`DCBC_CMD_STUFF, 8'h5a});
    cmd('{`DCBC_CMD_EXEC, 8'h5a});
    tick(1);
    i_op_len = 3'h3;
    cmd('{`DCBC_CMD_EXEC, 8'h5a, 8'h01, 8'h02});
    drain("crc and stepping");
    `CHK({n_step, n_stuff, n_exec, n_last, n_pmwr}, 40'h0101040201)
    ex('{8'hff, 8'hc0, 8'h00, 8'h80});
    cmd('{`DCBC_CMD_WR_CTL, 8'h60});
    breakpoint_opcode;
    tick(6);
    cmd('{`DCBC_CMD_RD_CTL});
    cmd('{`DCBC_CMD_WR_CTL, 8'h00});
    breakpoint_opcode;
    cmd('{`DCBC_CMD_RD_STAT});
    cmd('{`DCBC_CMD_WR_CTL, 8'h50});
    breakpoint_opcode;
    cmd('{`DCBC_CMD_RD_STAT});
    drain("breakpoints");
    cmd('{`DCBC_CMD_WR_CTL, 8'h84});
    i_cnt_wdata = 16'($urandom_range(9, 2));
    i_cnt_wr = 1;
    tick(1);
    i_cnt_wr = 0;
    cmd('{`DCBC_CMD_WR_CTL, 8'h04});
    tick(14);
    ex('{8'h84});
    cmd('{`DCBC_CMD_RD_CTL});
    drain("counter break");
    i_cnt_wdata = 16'($urandom);
    i_cnt_wr = 1;
    tick(1);
    i_cnt_wr = 0;
    cmd('{`DCBC_CMD_WR_CTL, 8'h08});
    tick(3);
    i_cpu_pc = i_cnt_wdata;
    tick(2);
    ex('{8'h88});
    cmd('{`DCBC_CMD_RD_CTL});
    drain("pc break");
    cmd('{`DCBC_CMD_WR_CTL, 8'h81});
    `CHK(o_dev_rst, 1'b1)
    tick(3);
    i_dev_rst_done = 1;
    tick(1);
    i_dev_rst_done = 0;
    tick(1);
    `CHK(o_dev_rst, 1'b0)
    ex('{8'h80});
    cmd('{`DCBC_CMD_RD_CTL});
    drain("device reset");
    close_out;
  end
endmodule
